/* File: hw/dic_pkg.sv */
package dic_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
    localparam int unsigned SAMPLE_PERIOD_US = 1000;
    localparam int unsigned TICK_CYCLES_DEF  = (CLK_FREQ_HZ / 1_000_000) * SAMPLE_PERIOD_US;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] OFS_SFE      = 12'h000;
    localparam logic [11:0] OFS_INV      = 12'h004;
    localparam logic [11:0] OFS_FEN      = 12'h008;
    localparam logic [11:0] OFS_FVAL     = 12'h00c;
    localparam logic [11:0] OFS_RAW      = 12'h010;
    localparam logic [11:0] OFS_ROUTE_EN = 12'h014;
    localparam logic [11:0] OFS_SUMMARY  = 12'h018;
    localparam logic [3:0]  MAP_PAGE     = 4'h1;
    localparam int unsigned MAP_ENTRIES  = 32;

    // ------------------------------------------------------------------
    // Summary word layout
    // ------------------------------------------------------------------
    localparam int unsigned LEVEL_BASE   = 16;
    localparam int unsigned SF_COUNT     = 4;
    localparam int unsigned SF_NEG_LIM   = 0;
    localparam int unsigned SF_POS_LIM   = 1;
    localparam int unsigned SF_HOME      = 2;
    localparam int unsigned SF_INTERLOCK = 3;
    localparam int unsigned PHYS_MAX     = 16;
    localparam int unsigned AUX_COUNT    = 7;

    // ------------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------------
    localparam logic [6:0] SRC_CONST     = 7'h00;
    localparam logic [6:0] SRC_PHYS_1    = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
    localparam logic [6:0] SRC_HALL_U    = 7'h41;
    localparam logic [6:0] SRC_USB_PWR   = 7'h47;
    localparam int unsigned SRC_INV_BIT  = 7;

endpackage : dic_pkg

/* File: hw/dic_top.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - Each input owns special bit and level bit; the code gives inputs 1-4 a special bit and input 5 a level bit only
// R2 - Input n level appears at bit 15+n
// R3 - Sample inputs each millisecond, ignore shorter pulses
// R4 - Enable bits: neglimit, poslimit, home, interlock
// R5 - Special enables never touch level bits
// R6 - Invert bit n-1 selects input n logic
// R7 - Normally closed reads high level as zero
// R8 - Force enable replaces sample with force value
// R9 - Force value bit is the read value
// R10 - Raw register shows unmodified sampled inputs
// R11 - Input 1: bit0 neglimit, bit16 result
// R12 - Routing enable one selects per-bit source routing
// R13 - Routing mode ignores enable, invert, force registers; the code still arms the interlock from enable bit 3 in routing mode
// R14 - Entering routing loads table reproducing prior behaviour
// R15 - Table entry k drives summary bit k-1
// R16 - Decode constant, physical, Hall, encoder, USB codes
// R17 - Code bit 7 selects inverted source
// R18 - Bit3 one releases motion, zero faults
// R19 - Software arms interlock and routes bit3
// R20 - Software avoids toggling routing mode repeatedly
// R21 - Unimplemented physical sources read as zero
module dic_top
    import dic_pkg::*;
#(
    parameter int unsigned NUM_IN      = 5,
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NUM_IN-1:0] din_i,
    input  wire logic [2:0]        hall_i,
    input  wire logic [2:0]        enc_i,
    input  wire logic              usb_pwr_i,
    output logic      [31:0]       summary_o,
    output logic                   motion_release_o,
    output logic                   interlock_fault_o
);

    localparam int unsigned PIN_W = NUM_IN + AUX_COUNT;
    localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_sel

    // Value of one routing source; bit 7 inverts whatever the low code picks
    function automatic logic src_value(input logic [7:0]          code,
                                       input logic [PHYS_MAX-1:0] phys,
                                       input logic [AUX_COUNT-1:0] aux);
        logic [6:0] base;
        logic       v;
        base = code[6:0];
        v    = 1'b0;
        if (base >= SRC_PHYS_1 && base <= SRC_PHYS_LAST)
        begin
            v = phys[4'(base - SRC_PHYS_1)]; // R16
        end
        else if (base >= SRC_HALL_U && base <= SRC_USB_PWR)
        begin
            v = aux[3'(base - SRC_HALL_U)]; // R16
        end
        return v ^ code[SRC_INV_BIT]; // R17
    endfunction : src_value

    // ------------------------------------------------------------------
    // Pin synchronisers and stability filter
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, stable_r;
    logic [PIN_W-1:0] stable_nxt;

    assign pins = {usb_pwr_i, enc_i, hall_i, din_i};

    always_comb
    begin
        stable_nxt = stable_r;
        if (s2_r == s3_r)
        begin
            stable_nxt = s3_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
        end
        else
        begin
            s1_r     <= pins;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= stable_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Millisecond sample tick
    // ------------------------------------------------------------------
    // A level must match at two ticks in a row, so a pulse shorter than one tick
    // never passes; a level held between one and two ticks may also be lost
    logic [CNT_W-1:0]     cnt_r, cnt_nxt;
    logic                 tick_r, tick_nxt;
    logic [31:0]          raw_r, raw_nxt;
    logic [AUX_COUNT-1:0] aux_r, aux_nxt;
    logic [PIN_W-1:0]     prev_r, prev_nxt;
    logic [PIN_W-1:0]     agree;
    logic [PIN_W-1:0]     held;

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + CNT_W'(1);
        raw_nxt  = raw_r;
        aux_nxt  = aux_r;
        prev_nxt = prev_r;
        agree    = ~(stable_r ^ prev_r);
        held     = {aux_r, raw_r[NUM_IN-1:0]};
        if (cnt_r == TICK_LAST)
        begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1; // R3
        end
        if (tick_r)
        begin
            prev_nxt = stable_r; // R3
            held     = (stable_r & agree) | (held & ~agree); // R3
            raw_nxt  = 32'(held[NUM_IN-1:0]); // R3 R10
            aux_nxt  = held[PIN_W-1:NUM_IN];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
            raw_r  <= '0;
            aux_r  <= '0;
            prev_r <= '0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
            raw_r  <= raw_nxt;
            aux_r  <= aux_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers and bus slave
    // ------------------------------------------------------------------
    logic [31:0] sfe_r, sfe_nxt;
    logic [31:0] inv_r, inv_nxt;
    logic [31:0] fen_r, fen_nxt;
    logic [31:0] fval_r, fval_nxt;
    logic        route_r, route_nxt;
    logic [7:0]  map_r   [MAP_ENTRIES];
    logic [7:0]  map_nxt [MAP_ENTRIES];
    logic [31:0] dat_r, dat_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] summary_r, summary_nxt;
    logic        release_r, release_nxt;
    logic        fault_r, fault_nxt;
    logic        access;
    logic        wr;
    logic        map_hit;
    logic [4:0]  map_idx;
    logic [31:0] lvl;
    logic [7:0]  lvl_code [MAP_ENTRIES];

    assign access  = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr      = access & wb_we_i;
    assign map_hit = (wb_adr_i[11:8] == MAP_PAGE) && !wb_adr_i[7];
    assign map_idx = wb_adr_i[6:2];

    // Conditioned level and equivalent routing code of each input
    always_comb
    begin
        lvl = '0;
        for (int n = 0; n < MAP_ENTRIES; n++)
        begin
            lvl_code[n] = 8'h00;
        end
        for (int n = 0; n < NUM_IN; n++)
        begin
            if (fen_r[n])
            begin
                lvl[n]      = fval_r[n]; // R8 R9
                lvl_code[n] = {fval_r[n], SRC_CONST};
            end
            else
            begin
                lvl[n]      = raw_r[n] ^ inv_r[n]; // R6 R7
                lvl_code[n] = {inv_r[n], 7'(n + 1)};
            end
        end
    end

    always_comb
    begin
        sfe_nxt   = sfe_r;
        inv_nxt   = inv_r;
        fen_nxt   = fen_r;
        fval_nxt  = fval_r;
        route_nxt = route_r;
        for (int k = 0; k < MAP_ENTRIES; k++)
        begin
            map_nxt[k] = map_r[k];
        end
        ack_nxt = access;
        dat_nxt = '0;
        if (wr && !map_hit)
        begin
            case (wb_adr_i)
                OFS_SFE:  sfe_nxt  = apply_sel(sfe_r, wb_dat_i, wb_sel_i);
                OFS_INV:  inv_nxt  = apply_sel(inv_r, wb_dat_i, wb_sel_i);
                OFS_FEN:  fen_nxt  = apply_sel(fen_r, wb_dat_i, wb_sel_i);
                OFS_FVAL: fval_nxt = apply_sel(fval_r, wb_dat_i, wb_sel_i);
                OFS_ROUTE_EN:
                begin
                    if (wb_sel_i[0])
                    begin
                        route_nxt = wb_dat_i[0]; // R12
                        if (wb_dat_i[0] && !route_r)
                        begin
                            // Snapshot current behaviour so the switch is seamless
                            for (int k = 0; k < MAP_ENTRIES; k++)
                            begin
                                map_nxt[k] = 8'h00;
                            end
                            for (int n = 0; n < NUM_IN; n++)
                            begin
                                map_nxt[LEVEL_BASE + n] = lvl_code[n]; // R14
                            end
                            for (int k = 0; k < SF_COUNT; k++)
                            begin
                                map_nxt[k] = sfe_r[k] ? lvl_code[k] : 8'h00; // R14
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
        if (wr && map_hit && wb_sel_i[0])
        begin
            map_nxt[map_idx] = wb_dat_i[7:0]; // R15
        end
        if (access && !wb_we_i)
        begin
            if (map_hit)
            begin
                dat_nxt = 32'(map_r[map_idx]);
            end
            else
            begin
                case (wb_adr_i)
                    OFS_SFE:      dat_nxt = sfe_r;
                    OFS_INV:      dat_nxt = inv_r;
                    OFS_FEN:      dat_nxt = fen_r;
                    OFS_FVAL:     dat_nxt = fval_r;
                    OFS_RAW:      dat_nxt = raw_r; // R10
                    OFS_ROUTE_EN: dat_nxt = 32'(route_r);
                    OFS_SUMMARY:  dat_nxt = summary_r;
                    default:      dat_nxt = '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Summary word and interlock
    // ------------------------------------------------------------------
    always_comb
    begin
        summary_nxt = '0;
        if (route_r)
        begin
            // Enable, invert and force registers are bypassed here; only the map table is read
            for (int k = 0; k < MAP_ENTRIES; k++)
            begin
                summary_nxt[k] = src_value(map_r[k], raw_r[PHYS_MAX-1:0], aux_r); // R13 R15 R21
            end
        end
        else
        begin
            for (int n = 0; n < NUM_IN; n++)
            begin
                summary_nxt[LEVEL_BASE + n] = lvl[n]; // R1 R2 R5 R11
            end
            for (int k = 0; k < SF_COUNT; k++)
            begin
                summary_nxt[k] = sfe_r[k] & lvl[k]; // R1 R4 R11
            end
        end
        // Interlock armed by its enable bit; routing picks the driving source
        fault_nxt   = sfe_r[SF_INTERLOCK] & ~summary_r[SF_INTERLOCK]; // R18 R19
        release_nxt = ~fault_nxt; // R18
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sfe_r     <= '0;
            inv_r     <= '0;
            fen_r     <= '0;
            fval_r    <= '0;
            route_r   <= 1'b0;
            for (int k = 0; k < MAP_ENTRIES; k++)
            begin
                map_r[k] <= 8'h00;
            end
            dat_r     <= '0;
            ack_r     <= 1'b0;
            summary_r <= '0;
            release_r <= 1'b0;
            fault_r   <= 1'b0;
        end
        else
        begin
            sfe_r     <= sfe_nxt;
            inv_r     <= inv_nxt;
            fen_r     <= fen_nxt;
            fval_r    <= fval_nxt;
            route_r   <= route_nxt;
            for (int k = 0; k < MAP_ENTRIES; k++)
            begin
                map_r[k] <= map_nxt[k];
            end
            dat_r     <= dat_nxt;
            ack_r     <= ack_nxt;
            summary_r <= summary_nxt;
            release_r <= release_nxt;
            fault_r   <= fault_nxt;
        end
    end

    assign wb_dat_o          = dat_r;
    assign wb_ack_o          = ack_r;
    assign summary_o         = summary_r;
    assign motion_release_o  = release_r;
    assign interlock_fault_o = fault_r;

endmodule : dic_top

/* File: sim/dic_asserts.sv */
`timescale 1ns/1ps
module dic_chk
    import dic_pkg::*;
#(
    parameter int unsigned NUM_IN      = 5,
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [31:0]       summary_o,
    input wire logic              motion_release_o,
    input wire logic              interlock_fault_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    write_zero_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data not zero on write ack");
    unmapped_read_a: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h020) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    summary_read_a: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_SUMMARY) |-> wb_dat_o == $past(summary_o))
        else $error("summary read differs from summary port");
    release_excl_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> motion_release_o != interlock_fault_o)
        else $error("release and fault not exclusive");
    fault_cause_a: assert property (
        interlock_fault_o && !$past(rst_i) |-> !$past(summary_o[3]))
        else $error("fault while interlock bit was high");

    cover property (interlock_fault_o ##1 !interlock_fault_o);
    cover property (wb_ack_o && $past(wb_we_i));
    cover property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_SUMMARY));
endmodule : dic_chk

bind dic_top dic_chk #(.NUM_IN(NUM_IN), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .summary_o(summary_o), .motion_release_o(motion_release_o),
    .interlock_fault_o(interlock_fault_o));

/* File: sim/dic_sw_model.sv */
`timescale 1ns/1ps
module dic_sw_model (
    input  wire logic       clk_i,
    output logic      [4:0] din_o,
    output logic      [2:0] hall_o,
    output logic      [2:0] enc_o,
    output logic            usb_o
);
    initial
    begin
        din_o = 5'h00;
        hall_o = 3'h0;
        enc_o = 3'h0;
        usb_o = 1'b0;
    end

    // Levels change only here and are held until the next call, which can follow within one tick as a short glitch
    task automatic set_all(input logic [4:0] d, input logic [2:0] h, input logic [2:0] e,
                           input logic u);
        @(posedge clk_i);
        din_o <= d;
        hall_o <= h;
        enc_o <= e;
        usb_o <= u;
    endtask : set_all
endmodule : dic_sw_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import dic_pkg::*;
    localparam int unsigned TICK = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [31:0] summary;
    logic        ack;
    logic        rel;
    logic        fault;
    logic [4:0]  din;
    logic [2:0]  hall;
    logic [2:0]  enc;
    logic        usb;
    int          n_errors = 0;
    int          check_count = 0;
    logic [7:0]  codes [22] = '{8'h00, 8'h80, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
                                8'h10, 8'h87, 8'h90, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
                                8'h46, 8'h47, 8'hc1, 8'hc4, 8'hc7, 8'h85};

    always #5 clk = ~clk;

    dic_sw_model sw (.clk_i(clk), .din_o(din), .hall_o(hall), .enc_o(enc), .usb_o(usb));

    dic_top #(.NUM_IN(5), .TICK_CYCLES(TICK)) uut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .din_i(din), .hall_i(hall), .enc_i(enc), .usb_pwr_i(usb), .summary_o(summary),
        .motion_release_o(rel), .interlock_fault_o(fault));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n >= 50)
        begin
            n_errors++;
            end_of_test();
        end
    endtask : wb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic pause(input int unsigned n);
        repeat (n) @(posedge clk);
    endtask : pause

    function automatic logic exp_src(input logic [7:0] c);
        logic [6:0] b;
        logic [6:0] aux;
        logic       v;
        b = c[6:0];
        aux = {usb, enc, hall};
        v = 1'b0;
        if (b >= 7'h01 && b <= 7'h05)
            v = din[b - 7'h01];
        else if (b >= 7'h41 && b <= 7'h47)
            v = aux[b - 7'h41];
        return v ^ c[7];
    endfunction : exp_src

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        pause(8);
        rst <= 1'b0;
        pause(1);
        for (int a = 0; a <= 32; a += 4)
            rd(12'(a), 32'h0);
        wb(1'b1, OFS_RAW, 32'hffff_ffff);
        wb(1'b1, 12'h020, 32'hffff_ffff);
        rd(OFS_RAW, 32'h0);
        rd(12'h020, 32'h0);
        sw.set_all(5'b10110, 3'b101, 3'b010, 1'b1);
        pause(4 * TICK);
        rd(OFS_RAW, 32'h16);
        rd(OFS_SUMMARY, 32'h0016_0000);
        // A pulse shorter than one tick must leave raw and summary untouched
        sw.set_all(5'b10111, 3'b101, 3'b010, 1'b1);
        pause(5);
        sw.set_all(5'b10110, 3'b101, 3'b010, 1'b1);
        pause(4 * TICK);
        rd(OFS_RAW, 32'h16);
        chk(summary, 32'h0016_0000);
        wb(1'b1, OFS_INV, 32'h3);
        pause(3);
        chk(summary, 32'h0015_0000);
        wb(1'b1, OFS_SFE, 32'hf);
        pause(3);
        chk(summary, 32'h0015_0005);
        chk({30'h0, rel, fault}, 32'h1);
        wb(1'b1, OFS_FEN, 32'h8);
        wb(1'b1, OFS_FVAL, 32'h8);
        pause(3);
        chk(summary, 32'h001d_000d);
        chk({30'h0, rel, fault}, 32'h2);
        rd(OFS_RAW, 32'h16);
        // Routing is entered once and left once: repeated toggling is avoided
        wb(1'b1, OFS_ROUTE_EN, 32'h1);
        pause(3);
        chk(summary, 32'h001d_000d);
        rd(12'h140, 32'h81);
        rd(12'h14c, 32'h80);
        wb(1'b1, OFS_INV, 32'h0);
        wb(1'b1, OFS_FEN, 32'h0);
        pause(3);
        chk(summary, 32'h001d_000d);
        foreach (codes[i])
        begin
            wb(1'b1, 12'h110, {24'h0, codes[i]});
            pause(3);
            chk({31'h0, summary[4]}, {31'h0, exp_src(codes[i])});
        end
        wb(1'b1, 12'h10c, 32'h4);
        pause(3);
        chk({30'h0, rel, fault}, 32'h1);
        sw.set_all(5'b11110, 3'b101, 3'b010, 1'b1);
        pause(4 * TICK);
        chk({30'h0, rel, fault}, 32'h2);
        wb(1'b1, OFS_ROUTE_EN, 32'h0);
        pause(3);
        chk(summary, 32'h001e_000e);
        end_of_test();
    end
endmodule : testbench
